// [hdl/vsense_pkg.sv]
// Constants, carriers and mode encodings for the voltage sensor core access.
// Assumes a single 40 MHz clock shared by the fabric controller and sensor.
// Functional notes
// - Eight-bit setup: mode, polarities, calibration, reserved
// - Modes 00/01/10 loop channels 2-7, 0-7, 0-1
// - Mode 11 converts the externally selected channel
// - Calibration bit gates calibration into result
// - Shift enable high eight cycles loads setup
// - Shift enable falling edge starts conversion
// - Conversion-done strobe per channel with result
// - Last channel asserts both strobes together
// - Sequence repeats until reset or reconfiguration
// - Reset clears registers, stops conversion
// - Setup loaded least significant bit first
// - Core access only while enable is high
package vsense_pkg;

    localparam int SETUP_W = 8;
    localparam int RESULT_W = 6;
    localparam int CHAN_W = 4;
    localparam int MODE_LSB = 0;
    localparam int POL0_BIT = 2;
    localparam int POL1_BIT = 3;
    localparam int CAL_BIT = 6;
    localparam logic [SETUP_W-1:0] SETUP_RESET = 8'h00;
    localparam logic [SETUP_W-1:0] SETUP_RSVD_MASK = 8'hb0;
    localparam logic [CHAN_W-1:0] CH_FIRST_LOW = 4'h0;
    localparam logic [CHAN_W-1:0] CH_FIRST_HIGH = 4'h2;
    localparam logic [CHAN_W-1:0] CH_LAST_ALL = 4'h7;
    localparam logic [CHAN_W-1:0] CH_LAST_PAIR = 4'h1;
    localparam logic [3:0] SHIFT_LEN = 4'h8;
    localparam logic [5:0] CAL_OFFSET = 6'h01;

    typedef enum logic [1:0] {
        MODE_CH2_TO_7 = 2'b00,
        MODE_CH0_TO_7 = 2'b01,
        MODE_CH0_TO_1 = 2'b10,
        MODE_EXTERNAL = 2'b11
    } seq_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONFIG = 2'b01,
        ST_CONVERT = 2'b10
    } conv_state_t;

    typedef struct packed {
        logic cal_enable;
        logic ch1_polarity;
        logic ch0_polarity;
        seq_mode_t sequencer_mode;
    } setup_fields_t;

    typedef struct packed {
        logic [CHAN_W-1:0] channel;
        logic last;
        logic [RESULT_W-1:0] value;
    } sample_t;

    localparam int SAMPLE_W = CHAN_W + 1 + RESULT_W;

endpackage

// [hdl/sample_fifo.sv]
// Parameterised synchronous FIFO with valid/ready on both sides.
// Assumes one clock; reset asynchronous active low.
module sample_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // Fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign in_ready_out = (count_q != (AW+1)'(DEPTH));
    assign out_valid_out = (count_q != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem[rd_ptr_q];

    always_ff @(posedge ref_clk_in) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    chk_fifo_bound: assert property (@(posedge ref_clk_in)
        disable iff (!rstn_in) count_q <= (AW+1)'(DEPTH))
        else $error("FIFO count exceeds depth");

endmodule // sample_fifo

// [hdl/vsense_access.sv]
// Sensor side of the core access port: serial setup, sequencer, strobes.
// Assumes the fabric controller follows the enable/reset/config sequence.
module vsense_access #(
    parameter int CONV_CYCLES = 80,
    parameter int FIFO_DEPTH = 32
) (
    // Clock and resets
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic sensor_reset_in,
    // Core access control
    input wire logic core_enable_in,
    input wire logic config_shift_in,
    input wire logic config_data_in,
    input wire logic [vsense_pkg::CHAN_W-1:0] chan_select_in,
    // Analogue result of current channel
    input wire logic [vsense_pkg::RESULT_W-1:0] adc_raw_in,
    // Strobes and data
    output logic conv_done_out,
    output logic seq_done_out,
    output logic [vsense_pkg::RESULT_W-1:0] result_out,
    output logic [vsense_pkg::CHAN_W-1:0] active_chan_out,
    // Buffered sample stream
    output logic sample_valid_out,
    input wire logic sample_ready_in,
    output logic [vsense_pkg::SAMPLE_W-1:0] sample_data_out
);
    localparam int CW = $clog2(CONV_CYCLES + 1);

    // ****************************************
    // Setup shift register
    // ****************************************
    logic [vsense_pkg::SETUP_W-1:0] setup_q;
    logic [3:0] shift_cnt_q;
    logic shift_prev_q;
    logic active;
    logic start_conv;
    vsense_pkg::setup_fields_t fields;

    assign active = core_enable_in && !sensor_reset_in;
    assign start_conv = active && shift_prev_q && !config_shift_in;
    assign fields = '{cal_enable: setup_q[vsense_pkg::CAL_BIT],
                      ch1_polarity: setup_q[vsense_pkg::POL1_BIT],
                      ch0_polarity: setup_q[vsense_pkg::POL0_BIT],
                      sequencer_mode: vsense_pkg::seq_mode_t'(
                          setup_q[vsense_pkg::MODE_LSB +: 2])};

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            setup_q <= vsense_pkg::SETUP_RESET;
            shift_cnt_q <= '0;
        end else if (!active) begin
            setup_q <= vsense_pkg::SETUP_RESET;
            shift_cnt_q <= '0;
        end else if (config_shift_in
                     && shift_cnt_q < vsense_pkg::SHIFT_LEN) begin
            // LSB first: new bit enters at top, walks down
            setup_q <= {config_data_in, setup_q[vsense_pkg::SETUP_W-1:1]};
            shift_cnt_q <= shift_cnt_q + 4'h1;
        end else if (!config_shift_in) begin
            shift_cnt_q <= '0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            shift_prev_q <= 1'b0;
        end else begin
            shift_prev_q <= config_shift_in && active;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    vsense_pkg::conv_state_t state_q;
    logic [CW-1:0] timer_q;
    logic [vsense_pkg::CHAN_W-1:0] chan_q;
    logic [vsense_pkg::CHAN_W-1:0] first_ch;
    logic [vsense_pkg::CHAN_W-1:0] last_ch;
    logic conv_end;
    logic is_last;
    logic external;

    assign external = fields.sequencer_mode == vsense_pkg::MODE_EXTERNAL;

    always_comb begin
        first_ch = vsense_pkg::CH_FIRST_LOW;
        last_ch = vsense_pkg::CH_LAST_ALL;
        case (fields.sequencer_mode)
            vsense_pkg::MODE_CH2_TO_7: begin
                first_ch = vsense_pkg::CH_FIRST_HIGH;
            end
            vsense_pkg::MODE_CH0_TO_7: begin
                last_ch = vsense_pkg::CH_LAST_ALL;
            end
            vsense_pkg::MODE_CH0_TO_1: begin
                last_ch = vsense_pkg::CH_LAST_PAIR;
            end
            default: begin
                first_ch = vsense_pkg::CH_FIRST_LOW;
            end
        endcase
    end

    assign conv_end = state_q == vsense_pkg::ST_CONVERT
                      && timer_q == CW'(CONV_CYCLES - 1);
    assign is_last = !external && chan_q == last_ch;

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= vsense_pkg::ST_IDLE;
        end else if (!active) begin
            state_q <= vsense_pkg::ST_IDLE;
        end else begin
            case (state_q)
                vsense_pkg::ST_IDLE: begin
                    if (config_shift_in) begin
                        state_q <= vsense_pkg::ST_CONFIG;
                    end
                end
                vsense_pkg::ST_CONFIG: begin
                    if (start_conv) begin
                        state_q <= vsense_pkg::ST_CONVERT;
                    end
                end
                vsense_pkg::ST_CONVERT: begin
                    // Reload mid-sequence is the controller's fault; obey it
                    if (config_shift_in) begin
                        state_q <= vsense_pkg::ST_CONFIG;
                    end
                end
                default: begin
                    state_q <= vsense_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            timer_q <= '0;
        end else if (!active || state_q != vsense_pkg::ST_CONVERT
                     || conv_end) begin
            timer_q <= '0;
        end else begin
            timer_q <= timer_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            chan_q <= '0;
        end else if (!active) begin
            chan_q <= '0;
        end else if (start_conv) begin
            chan_q <= external ? chan_select_in : first_ch;
        end else if (conv_end) begin
            if (external) begin
                chan_q <= chan_select_in;
            end else if (is_last) begin
                chan_q <= first_ch;
            end else begin
                chan_q <= chan_q + 1'b1;
            end
        end
    end

    // ****************************************
    // Strobes and result
    // ****************************************
    logic [vsense_pkg::RESULT_W-1:0] value;

    // Calibration trim only applied when enabled
    assign value = fields.cal_enable ? adc_raw_in + vsense_pkg::CAL_OFFSET
                                     : adc_raw_in;

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            conv_done_out <= 1'b0;
            seq_done_out <= 1'b0;
            result_out <= '0;
            active_chan_out <= '0;
        end else if (!active) begin
            // Sensor reset clears its result registers too
            conv_done_out <= 1'b0;
            seq_done_out <= 1'b0;
            result_out <= '0;
            active_chan_out <= '0;
        end else begin
            conv_done_out <= conv_end && active;
            seq_done_out <= conv_end && active && is_last;
            if (conv_end) begin
                result_out <= value;
                active_chan_out <= chan_q;
            end
        end
    end

    // ****************************************
    // Sample FIFO
    // ****************************************
    vsense_pkg::sample_t sample;
    logic fifo_ready;

    assign sample = '{channel: active_chan_out, last: seq_done_out,
                      value: result_out};

    sample_fifo #(
        .WIDTH(vsense_pkg::SAMPLE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .in_valid_in(conv_done_out),
        .in_ready_out(fifo_ready),
        .in_data_in(sample),
        .out_valid_out(sample_valid_out),
        .out_ready_in(sample_ready_in),
        .out_data_out(sample_data_out)
    );

    // ****************************************
    // Checks
    // ****************************************
    chk_strobe_single: assert property (@(posedge ref_clk_in)
        disable iff (!rstn_in) conv_done_out |=> !conv_done_out)
        else $error("Conversion strobe longer than one cycle");
    chk_seq_with_conv: assert property (@(posedge ref_clk_in)
        disable iff (!rstn_in) seq_done_out |-> conv_done_out)
        else $error("Sequence strobe without conversion strobe");
    chk_no_conv_reset: assert property (@(posedge ref_clk_in)
        disable iff (!rstn_in) !active |=> !conv_done_out && !seq_done_out
        && result_out == '0 && state_q == vsense_pkg::ST_IDLE)
        else $error("Strobe while inactive");
    chk_start_first: assert property (@(posedge ref_clk_in)
        disable iff (!rstn_in) start_conv && !external
        |=> chan_q == $past(first_ch))
        else $error("Sequence did not start on first channel");
    chk_ext_channel: assert property (@(posedge ref_clk_in)
        disable iff (!rstn_in) start_conv && external
        |=> chan_q == $past(chan_select_in))
        else $error("External channel not taken");
    chk_shift_lsb: assert property (@(posedge ref_clk_in)
        disable iff (!rstn_in) active && config_shift_in && shift_cnt_q == '0
        ##1 (active && config_shift_in) [*7]
        |=> setup_q[0] == $past(config_data_in, 8))
        else $error("First shifted bit not in bit zero");
    chk_wrap_first: assert property (@(posedge ref_clk_in)
        disable iff (!rstn_in) conv_end && is_last && active
        && !config_shift_in |=> chan_q == first_ch)
        else $error("Sequence did not wrap");
    chk_result_cal: assert property (@(posedge ref_clk_in)
        disable iff (!rstn_in) conv_end && !fields.cal_enable
        |=> result_out == $past(adc_raw_in))
        else $error("Uncalibrated result altered");
    chk_start_edge: assert property (@(posedge ref_clk_in)
        disable iff (!rstn_in) start_conv && state_q == vsense_pkg::ST_CONFIG
        |=> state_q == vsense_pkg::ST_CONVERT)
        else $error("Shift enable fall did not start conversion");
    chk_fifo_accept: assert property (@(posedge ref_clk_in)
        disable iff (!rstn_in) conv_done_out |-> fifo_ready)
        else $error("Sample dropped by full FIFO");

    cov_seq_done: cover property (@(posedge ref_clk_in) seq_done_out);
    cov_external: cover property (@(posedge ref_clk_in)
        conv_done_out && external);
    cov_pair_mode: cover property (@(posedge ref_clk_in)
        seq_done_out && fields.sequencer_mode == vsense_pkg::MODE_CH0_TO_1);

endmodule // vsense_access

// [verification/fabric_ctl_model.sv]
// Behavioural fabric controller that drives the sensor's core access port.
// Assumes one clock; drives on falling edges, captures results per strobe.
module fabric_ctl_model (
    // Clock
    input wire logic ref_clk_in,
    // Sensor strobes and data
    input wire logic conv_done_in,
    input wire logic seq_done_in,
    input wire logic [vsense_pkg::RESULT_W-1:0] result_in,
    input wire logic [vsense_pkg::CHAN_W-1:0] active_chan_in,
    // Core access control
    output logic core_enable_out,
    output logic sensor_reset_out,
    output logic config_shift_out,
    output logic config_data_out,
    output logic [vsense_pkg::CHAN_W-1:0] chan_select_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // ********************************
    // Capture and setup sequencing
    // ********************************
    logic [10:0] got_q[$];
    logic [3:0] ext_q[$];

    initial begin
        core_enable_out = 1'b0;
        sensor_reset_out = 1'b1;
        config_shift_out = 1'b0;
        config_data_out = 1'b0;
        chan_select_out = 4'h0;
    end

    // Result stands after the strobe; taking it here equals its fall
    always @(negedge ref_clk_in) begin
        if (conv_done_in === 1'b1) begin
            got_q.push_back({active_chan_in, seq_done_in, result_in});
            if (ext_q.size() > 0) begin
                chan_select_out <= ext_q.pop_front();
            end
        end
    end

    task set_reset(input logic v);
        sensor_reset_out = v;
    endtask

    task start_setup(input logic [7:0] setup, input logic [3:0] chan,
                     input logic en);
        logic [7:0] s;
        int i;
        begin
            // Reserved and polarity bits always go out as zero
            s = setup & ~vsense_pkg::SETUP_RSVD_MASK & ~8'h0c;
            @(negedge ref_clk_in);
            core_enable_out = 1'b0;
            sensor_reset_out = 1'b1;
            got_q.delete();
            repeat (2) @(negedge ref_clk_in);
            core_enable_out = en;
            repeat (2) @(negedge ref_clk_in);
            sensor_reset_out = 1'b0;
            chan_select_out = chan;
            repeat (2) @(negedge ref_clk_in);
            for (i = 0; i < 8; i++) begin
                config_shift_out = 1'b1;
                config_data_out = s[i];
                @(negedge ref_clk_in);
            end
            config_shift_out = 1'b0;
            // Line released: show the inverse so a stale sample is caught
            config_data_out = ~s[7];
            @(negedge ref_clk_in);
            if (ext_q.size() > 0) begin
                chan_select_out = ext_q.pop_front();
            end
        end
    endtask
endmodule // fabric_ctl_model

// [verification/voltage_sensor_core_access_tb.sv]
// Self-checking bench for the sensor access block and its sample FIFO.
// Assumes the design's assertions guard cycle timing; this checks values.
module voltage_sensor_core_access_tb;
    timeunit 1ns;
    timeprecision 100ps;
    // ********************************
    // Clock, reset, instances
    // ********************************
    logic ref_clk_in, rstn_in, sample_ready, core_enable, sensor_reset;
    logic config_shift, config_data, conv_done, seq_done, sample_valid;
    logic [3:0] chan_select, active_chan;
    logic [5:0] result, adc_raw;
    logic [10:0] sample_data;
    logic [10:0] exp_q[$];
    logic [3:0] ext_tab[5] = '{4'h5, 4'h3, 4'h0, 4'h7, 4'h6};
    int n_mismatch = 0;
    int total_checks = 0;
    int i;

    initial begin
        ref_clk_in = 1'b0;
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end

    vsense_access #(.CONV_CYCLES(4), .FIFO_DEPTH(32)) i_dut (
        .ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
        .sensor_reset_in(sensor_reset), .core_enable_in(core_enable),
        .config_shift_in(config_shift), .config_data_in(config_data),
        .chan_select_in(chan_select), .adc_raw_in(adc_raw),
        .conv_done_out(conv_done), .seq_done_out(seq_done),
        .result_out(result), .active_chan_out(active_chan),
        .sample_valid_out(sample_valid), .sample_ready_in(sample_ready),
        .sample_data_out(sample_data));

    fabric_ctl_model i_ctl (
        .ref_clk_in(ref_clk_in), .conv_done_in(conv_done),
        .seq_done_in(seq_done), .result_in(result),
        .active_chan_in(active_chan), .core_enable_out(core_enable),
        .sensor_reset_out(sensor_reset), .config_shift_out(config_shift),
        .config_data_out(config_data), .chan_select_out(chan_select));

    // ********************************
    // Checking tasks
    // ********************************
    task give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task check(input logic [15:0] seen, input logic [15:0] exp,
               input string what);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h want %h",
                     $time, what, seen, exp);
        end
    endtask

    task wait_sample(output logic [10:0] s);
        int n;
        begin
            n = 0;
            while (i_ctl.got_q.size() == 0 && n < 200) begin
                @(negedge ref_clk_in);
                n++;
            end
            if (i_ctl.got_q.size() == 0) begin
                n_mismatch++;
                $display("CHECK FAILED at %0t: no conversion", $time);
                give_verdict();
            end else begin
                s = i_ctl.got_q.pop_front();
            end
        end
    endtask

    // Expected channel order is worked out here, not read back
    task run_seq(input logic [7:0] setup, input int n);
        logic [10:0] s, e;
        logic [3:0] c, first, last;
        logic [5:0] v;
        logic ext;
        int k;
        begin
            ext = setup[1:0] == vsense_pkg::MODE_EXTERNAL;
            first = setup[1:0] == 2'b00 ? 4'h2 : 4'h0;
            last = setup[1:0] == 2'b10 ? 4'h1 : 4'h7;
            v = setup[6] ? adc_raw + vsense_pkg::CAL_OFFSET : adc_raw;
            c = ext ? ext_tab[0] : first;
            for (k = 1; ext && k < 5; k++) begin
                i_ctl.ext_q.push_back(ext_tab[k]);
            end
            i_ctl.start_setup(setup, c, 1'b1);
            for (k = 0; k < n; k++) begin
                wait_sample(s);
                e = {c, !ext && c == last, v};
                check(s, e, "sample");
                exp_q.push_back(e);
                c = ext ? ext_tab[k+1] : (c == last ? first : c + 4'h1);
            end
        end
    endtask

    // ********************************
    // Scenarios
    // ********************************
    initial begin
        rstn_in = 1'b0;
        sample_ready = 1'b0;
        adc_raw = 6'h15;
        repeat (5) @(negedge ref_clk_in);
        rstn_in = 1'b1;
        @(negedge ref_clk_in);
        check({conv_done, seq_done, sample_valid, result}, 0, "rst");
        // Fill the FIFO with the drain stalled, then stop the sensor
        run_seq(8'h41, 32);
        i_ctl.set_reset(1'b1);
        repeat (10) @(negedge ref_clk_in);
        check(sample_valid, 1'b1, "fifo full held");
        i = 0;
        while (exp_q.size() > 0 && i < 300) begin
            @(negedge ref_clk_in);
            i++;
            if (sample_valid === 1'b1) begin
                check(sample_data, exp_q.pop_front(), "fifo data");
                sample_ready = 1'b1;
            end else begin
                sample_ready = 1'b0;
            end
        end
        if (exp_q.size() > 0) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: drain timed out", $time);
            give_verdict();
        end
        @(negedge ref_clk_in);
        check({exp_q.size() == 0, sample_valid}, 2'b10, "fifo empty");
        sample_ready = 1'b1;
        run_seq(8'h00, 12);
        run_seq(8'h42, 4);
        run_seq(8'h03, 4);
        exp_q.delete();
        // Shifting with access disabled must start nothing
        i_ctl.start_setup(8'h01, 4'h0, 1'b0);
        repeat (40) @(negedge ref_clk_in);
        check(i_ctl.got_q.size(), 0, "refused");
        // Sensor reset in mid-sequence stops conversions
        run_seq(8'h01, 3);
        i_ctl.set_reset(1'b1);
        repeat (3) @(negedge ref_clk_in);
        i_ctl.got_q.delete();
        repeat (30) @(negedge ref_clk_in);
        check(i_ctl.got_q.size(), 0, "reset stop");
        check({conv_done, seq_done, result}, 0, "reset clear");
        give_verdict();
    end
endmodule // voltage_sensor_core_access_tb
